// file: core/adc_seq_pkg.sv
// Shared constants for the converter sequencer: register indices, field layout,
// reset values, clock codes, sequencer states and conversion timing.
// Assumes a 32-bit APB master; each register index maps to byte address index*4.
package adc_seq_pkg;
    localparam int ADDR_W = 12;
    localparam logic [9:0] IDX_RESULT_HIGH = 10'h01E;
    localparam logic [9:0] IDX_CONTROL = 10'h01F;
    localparam logic [9:0] IDX_RESULT_LOW = 10'h09E;
    localparam logic [9:0] IDX_PORT_CONFIG = 10'h09F;
    localparam logic [9:0] IDX_DONE_STATUS = 10'h0C0;

    localparam int CTL_CLK_LSB = 6;
    localparam int CTL_CHAN_LSB = 3;
    localparam int CTL_GO_BIT = 2;
    localparam int CTL_ON_BIT = 0;
    localparam int CFG_JUSTIFY_BIT = 7;
    localparam int STS_DONE_BIT = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] PORT_CONFIG_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;

    localparam logic [1:0] CLK_DIV2 = 2'b00;
    localparam logic [1:0] CLK_DIV8 = 2'b01;
    localparam logic [1:0] CLK_DIV32 = 2'b10;
    localparam logic [1:0] CLK_RC = 2'b11;
    localparam logic [5:0] DIV2_CYCLES = 6'h02;
    localparam logic [5:0] DIV8_CYCLES = 6'h08;
    localparam logic [5:0] DIV32_CYCLES = 6'h20;

    localparam int RESULT_BITS = 10;
    localparam logic [3:0] LAST_STEP = 4'hB;
    localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;
    localparam int CLK_PERIOD_NS = 100;
    localparam int BIT_PERIOD_MIN_NS = 1600;
    localparam int BIT_PERIOD_MIN_CYCLES =
        (BIT_PERIOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_convert = 2'b01
    } seq_state_t;
endpackage

// file: core/adc_sequencer_control.sv
// Control logic of a five-channel 10-bit successive-approximation converter.
// Assumes an APB master on pclk and an analog core that answers comp_in each cycle.
//
// What this block does
// - Clock code picks divide 2, 8, 32 or RC
// - Channel code 0 to 4 selects input
// - Writing go while on starts conversion
// - Go clears itself when conversion finishes
// - Converter-on bit enables module, else off
// - Unimplemented control bits read as zero
// - Justify one gives right-aligned result
// - Justify zero gives left-aligned result
// - Code 0000 all analog, 011x all digital
// - Reference pin codes and single-channel code 1110
// - Completion loads result, clears go, sets done
// - Conversion lasts twelve bit periods; with RC the first one can be short
// - RC source times conversions from its oscillator
// - Control registers reset to zero
// - Clearing go aborts, result kept unchanged
// - Reset turns off, aborts, pins analog
`timescale 1ns/1ns
module adc_sequencer_control (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic comp_in,
    input wire logic rc_tick,
    output logic converter_enable,
    output logic [2:0] channel_select,
    output logic sample_connect,
    output logic [9:0] sar_trial,
    output logic [4:0] pin_analog,
    output logic vref_pos_pin,
    output logic vref_neg_pin,
    output logic conv_done_flag
);
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [1:0] clk_sel_q;
    logic [2:0] chan_q;
    logic go_q;
    logic on_q;
    logic justify_q;
    logic [3:0] code_q;
    logic [7:0] res_high_q;
    logic [7:0] res_low_q;
    logic done_q;
    logic sample_q;
    logic [4:0] pin_analog_q;
    logic vpos_q;
    logic vneg_q;
    adc_seq_pkg::seq_state_t state_q;
    logic [3:0] step_q;
    logic [9:0] sar_q;
    logic [9:0] sar_d;
    logic tick;
    logic [4:0] map_analog;
    logic map_vpos;
    logic map_vneg;
    logic [9:0] index;
    logic mapped;
    logic access;
    logic wr_ctl;
    logic wr_cfg;
    logic wr_high;
    logic wr_low;
    logic wr_sts;
    logic start;
    logic abort;
    logic done_evt;
    logic converting;
    logic [7:0] ctl_read;
    logic [7:0] cfg_read;
    logic [31:0] rd_mux;

    assign index = paddr[11:2];
    assign mapped = (paddr[1:0] == 2'b00) &&
        (index == adc_seq_pkg::IDX_CONTROL || index == adc_seq_pkg::IDX_PORT_CONFIG ||
         index == adc_seq_pkg::IDX_RESULT_HIGH || index == adc_seq_pkg::IDX_RESULT_LOW ||
         index == adc_seq_pkg::IDX_DONE_STATUS);
    // A write takes effect only in the access cycle that the slave completes.
    assign access = psel && penable && pready_q;
    assign wr_ctl = access && pwrite && mapped && index == adc_seq_pkg::IDX_CONTROL;
    assign wr_cfg = access && pwrite && mapped && index == adc_seq_pkg::IDX_PORT_CONFIG;
    assign wr_high = access && pwrite && mapped && index == adc_seq_pkg::IDX_RESULT_HIGH;
    assign wr_low = access && pwrite && mapped && index == adc_seq_pkg::IDX_RESULT_LOW;
    assign wr_sts = access && pwrite && mapped && index == adc_seq_pkg::IDX_DONE_STATUS;

    assign converting = (state_q == adc_seq_pkg::st_convert);
    // The converter must already be on; a write turning it on cannot also start it.
    assign start = wr_ctl && !go_q && on_q && pwdata[adc_seq_pkg::CTL_GO_BIT] &&
        pwdata[adc_seq_pkg::CTL_ON_BIT];
    assign abort = wr_ctl && (!pwdata[adc_seq_pkg::CTL_GO_BIT] ||
        !pwdata[adc_seq_pkg::CTL_ON_BIT]);
    assign done_evt = converting && tick && step_q == adc_seq_pkg::LAST_STEP &&
        !abort;

    assign ctl_read = {clk_sel_q, chan_q, go_q, 1'b0, on_q};
    assign cfg_read = {justify_q, 3'b000, code_q};

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (index)
            adc_seq_pkg::IDX_CONTROL: rd_mux = {24'h00_0000, ctl_read};
            adc_seq_pkg::IDX_PORT_CONFIG: rd_mux = {24'h00_0000, cfg_read};
            adc_seq_pkg::IDX_RESULT_HIGH: rd_mux = {24'h00_0000, res_high_q};
            adc_seq_pkg::IDX_RESULT_LOW: rd_mux = {24'h00_0000, res_low_q};
            adc_seq_pkg::IDX_DONE_STATUS: rd_mux = {31'h0000_0000, done_q};
            default: rd_mux = 32'h0000_0000;
        endcase
        if (!mapped) begin
            rd_mux = 32'h0000_0000;
        end
    end

    // Every transfer gets exactly one wait-free access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= psel && !penable;
            pslverr_q <= psel && !penable && !mapped;
            if (psel && !penable) begin
                prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    // Control register: clock, channel and enable bits.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_sel_q <= adc_seq_pkg::CONTROL_RESET[7:6];
            chan_q <= adc_seq_pkg::CONTROL_RESET[5:3];
            on_q <= adc_seq_pkg::CONTROL_RESET[0];
        end else if (wr_ctl) begin
            clk_sel_q <= pwdata[adc_seq_pkg::CTL_CLK_LSB +: 2];
            chan_q <= pwdata[adc_seq_pkg::CTL_CHAN_LSB +: 3];
            on_q <= pwdata[adc_seq_pkg::CTL_ON_BIT];
        end
    end

    // Go flag: set by software, cleared by completion, abort or turn-off.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            go_q <= adc_seq_pkg::CONTROL_RESET[2];
        end else if (done_evt) begin
            go_q <= 1'b0;
        end else if (wr_ctl) begin
            go_q <= pwdata[adc_seq_pkg::CTL_GO_BIT] && pwdata[adc_seq_pkg::CTL_ON_BIT] &&
                on_q;
        end else if (!on_q) begin
            go_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            justify_q <= adc_seq_pkg::PORT_CONFIG_RESET[7];
            code_q <= adc_seq_pkg::PORT_CONFIG_RESET[3:0];
        end else if (wr_cfg) begin
            justify_q <= pwdata[adc_seq_pkg::CFG_JUSTIFY_BIT];
            code_q <= pwdata[3:0];
        end
    end

    port_map_decode u_map (
        .port_config_code(code_q),
        .pin_analog(map_analog),
        .vref_pos_pin(map_vpos),
        .vref_neg_pin(map_vneg)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_analog_q <= 5'h1F;
            vpos_q <= 1'b0;
            vneg_q <= 1'b0;
        end else begin
            pin_analog_q <= map_analog;
            vpos_q <= map_vpos;
            vneg_q <= map_vneg;
        end
    end

    bit_period_tick u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .run(converting),
        .clock_select(clk_sel_q),
        .rc_tick(rc_tick),
        .tick_q(tick)
    );

    // Step 0 resolves no bit, steps 1 to 10 resolve bits 9 down to 0.
    always_comb begin
        sar_d = sar_q;
        for (int i = 0; i < adc_seq_pkg::RESULT_BITS; i++) begin
            if (4'(10 - i) == step_q) begin
                sar_d[i] = comp_in;
            end
            if (4'(9 - i) == step_q && i < 9) begin
                sar_d[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= adc_seq_pkg::st_idle;
            step_q <= 4'h0;
            sar_q <= 10'h000;
        end else begin
            case (state_q)
                adc_seq_pkg::st_idle: begin
                    if (start) begin
                        state_q <= adc_seq_pkg::st_convert;
                        step_q <= 4'h0;
                        sar_q <= adc_seq_pkg::SAR_FIRST_TRIAL;
                    end
                end
                adc_seq_pkg::st_convert: begin
                    if (abort || !on_q) begin
                        state_q <= adc_seq_pkg::st_idle;
                    end else if (tick) begin
                        if (step_q == adc_seq_pkg::LAST_STEP) begin
                            state_q <= adc_seq_pkg::st_idle;
                        end else begin
                            step_q <= step_q + 4'h1;
                            sar_q <= sar_d;
                        end
                    end
                end
                default: state_q <= adc_seq_pkg::st_idle;
            endcase
        end
    end

    // Result pair; a completion overrides a software write in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_high_q <= adc_seq_pkg::RESULT_RESET;
            res_low_q <= adc_seq_pkg::RESULT_RESET;
        end else if (done_evt) begin
            if (justify_q) begin
                res_high_q <= {6'h00, sar_q[9:8]};
                res_low_q <= sar_q[7:0];
            end else begin
                res_high_q <= sar_q[9:2];
                res_low_q <= {sar_q[1:0], 6'h00};
            end
        end else begin
            if (wr_high) begin
                res_high_q <= pwdata[7:0];
            end
            if (wr_low) begin
                res_low_q <= pwdata[7:0];
            end
        end
    end

    // Done flag: a completion in the cycle of a clearing write still sets it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
        end else if (done_evt) begin
            done_q <= 1'b1;
        end else if (wr_sts) begin
            done_q <= pwdata[adc_seq_pkg::STS_DONE_BIT];
        end
    end

    // Acquisition runs whenever the converter is on and not converting.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_q <= 1'b0;
        end else begin
            sample_q <= on_q && !(converting && !abort) && !start;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign converter_enable = on_q;
    assign channel_select = chan_q;
    assign sample_connect = sample_q;
    assign sar_trial = sar_q;
    assign pin_analog = pin_analog_q;
    assign vref_pos_pin = vpos_q;
    assign vref_neg_pin = vneg_q;
    assign conv_done_flag = done_q;

    // Checking helper: ticks seen since the last start.
    logic [3:0] ticks_seen_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ticks_seen_q <= 4'h0;
        end else if (start) begin
            ticks_seen_q <= 4'h0;
        end else if (converting && tick) begin
            ticks_seen_q <= ticks_seen_q + 4'h1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_started;
        start ##1 (go_q && converting);
    endsequence

    sequence s_finished;
        done_evt ##1 (!go_q && done_q && !converting);
    endsequence

    property p_start;
        start |-> s_started;
    endproperty
    a_start: assert property (p_start) else $error("Start did not begin conversion.");

    property p_finish;
        done_evt |-> s_finished;
    endproperty
    a_finish: assert property (p_finish) else $error("Completion effects missing.");

    property p_go_reads_busy;
        converting && !abort && !done_evt |=> go_q;
    endproperty
    a_go_reads_busy: assert property (p_go_reads_busy) else $error("Go low while busy.");

    property p_twelve;
        done_evt |-> ticks_seen_q == 4'hB && tick;
    endproperty
    a_twelve: assert property (p_twelve) else $error("Conversion not twelve periods.");

    property p_right;
        done_evt && justify_q |=> res_high_q[7:2] == 6'h00 && res_low_q == $past(sar_q[7:0]);
    endproperty
    a_right: assert property (p_right) else $error("Right justify wrong.");

    property p_left;
        done_evt && !justify_q |=> res_low_q[5:0] == 6'h00 && res_high_q == $past(sar_q[9:2]);
    endproperty
    a_left: assert property (p_left) else $error("Left justify wrong.");

    property p_abort;
        converting && abort |=> !converting && $stable(res_high_q) && $stable(res_low_q);
    endproperty
    a_abort: assert property (p_abort) else $error("Abort changed result.");

    property p_off;
        !on_q |=> !converting && !go_q;
    endproperty
    a_off: assert property (p_off) else $error("Module runs while off.");

    property p_ctl_read;
        pready_q && psel && !pwrite && paddr == {adc_seq_pkg::IDX_CONTROL, 2'b00}
            |-> prdata_q[1] == 1'b0 && prdata_q[31:8] == 24'h00_0000;
    endproperty
    a_ctl_read: assert property (p_ctl_read) else $error("Reserved bit reads one.");

    property p_all_digital;
        code_q[3:1] == 3'b011 |=> pin_analog_q == 5'h00;
    endproperty
    a_all_digital: assert property (p_all_digital) else $error("Digital code wrong.");

    property p_single;
        code_q == 4'hE |=> pin_analog_q == 5'h01 && !vpos_q;
    endproperty
    a_single: assert property (p_single) else $error("Code 1110 map wrong.");
endmodule

// file: core/bit_period_tick.sv
// Bit-period tick generator for the conversion sequencer.
// Assumes rc_tick is a one-cycle pulse per internal RC oscillator period.
`timescale 1ns/1ns
module bit_period_tick (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [1:0] clock_select,
    input wire logic rc_tick,
    output logic tick_q
);
    logic [5:0] count_q;
    logic [5:0] period;

    always_comb begin
        case (clock_select)
            adc_seq_pkg::CLK_DIV2: period = adc_seq_pkg::DIV2_CYCLES;
            adc_seq_pkg::CLK_DIV8: period = adc_seq_pkg::DIV8_CYCLES;
            default: period = adc_seq_pkg::DIV32_CYCLES;
        endcase
    end

    // The count restarts on every start so the first divider period is never short of a cycle; in RC mode the first tick can come at once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= 6'h00;
            tick_q <= 1'b0;
        end else if (!run) begin
            count_q <= 6'h00;
            tick_q <= 1'b0;
        end else if (clock_select == adc_seq_pkg::CLK_RC) begin
            tick_q <= rc_tick;
        end else if (count_q == period - 6'h01) begin
            count_q <= 6'h00;
            tick_q <= 1'b1;
        end else begin
            count_q <= count_q + 6'h01;
            tick_q <= 1'b0;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_div2_period;
        (run && clock_select == adc_seq_pkg::CLK_DIV2 && tick_q) ##1
            (run && clock_select == adc_seq_pkg::CLK_DIV2) [*2] |-> tick_q && !$past(tick_q);
    endproperty
    a_div2_period: assert property (p_div2_period) else $error("Divide-by-2 period wrong.");

    property p_rc_follow;
        run && clock_select == adc_seq_pkg::CLK_RC |=> tick_q == $past(rc_tick);
    endproperty
    a_rc_follow: assert property (p_rc_follow) else $error("RC tick not followed.");
endmodule

// file: core/port_map_decode.sv
// Decodes the port configuration code into analog pin mask and reference sources.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ns
module port_map_decode (
    input wire logic [3:0] port_config_code,
    output logic [4:0] pin_analog,
    output logic vref_pos_pin,
    output logic vref_neg_pin
);
    logic [6:0] map;

    // Mask order is channel 4 down to channel 0; reference pins count as analog.
    always_comb begin
        case (port_config_code)
            4'h0: map = 7'h7C;
            4'h1: map = 7'h7E;
            4'h2: map = 7'h7C;
            4'h3: map = 7'h7E;
            4'h4: map = 7'h2C;
            4'h5: map = 7'h2E;
            4'h6: map = 7'h00;
            4'h7: map = 7'h00;
            4'h8: map = 7'h7F;
            4'h9: map = 7'h7C;
            4'hA: map = 7'h7E;
            4'hB: map = 7'h7F;
            4'hC: map = 7'h7F;
            4'hD: map = 7'h3F;
            4'hE: map = 7'h04;
            default: map = 7'h37;
        endcase
    end

    assign pin_analog = map[6:2];
    assign vref_pos_pin = map[1];
    assign vref_neg_pin = map[0];
endmodule

// file: sim/adc_sequencer_control_tb.sv
// Self-checking bench for the converter sequencer with a behavioural analog core.
// Assumes the APB map and timing of the design package, on a 10 MHz pclk.
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module adc_sequencer_control_tb;
    localparam logic [11:0] A_HI = {adc_seq_pkg::IDX_RESULT_HIGH, 2'b00};
    localparam logic [11:0] A_CTL = {adc_seq_pkg::IDX_CONTROL, 2'b00};
    localparam logic [11:0] A_LO = {adc_seq_pkg::IDX_RESULT_LOW, 2'b00};
    localparam logic [11:0] A_CFG = {adc_seq_pkg::IDX_PORT_CONFIG, 2'b00};
    localparam logic [11:0] A_STS = {adc_seq_pkg::IDX_DONE_STATUS, 2'b00};
    localparam int RC_DIV = 30;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, comp_in, rc_tick, converter_enable, sample_connect;
    logic vref_pos_pin, vref_neg_pin, conv_done_flag;
    logic [2:0] channel_select;
    logic [9:0] sar_trial;
    logic [9:0] level = 10'h000;
    logic [4:0] pin_analog;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [6:0] pmap [16] = '{7'h7C, 7'h7E, 7'h7C, 7'h7E, 7'h2C, 7'h2E, 7'h00, 7'h00,
        7'h7F, 7'h7C, 7'h7E, 7'h7F, 7'h7F, 7'h3F, 7'h04, 7'h37};
    adc_sequencer_control uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .comp_in(comp_in),
        .rc_tick(rc_tick), .converter_enable(converter_enable),
        .channel_select(channel_select), .sample_connect(sample_connect),
        .sar_trial(sar_trial), .pin_analog(pin_analog), .vref_pos_pin(vref_pos_pin),
        .vref_neg_pin(vref_neg_pin), .conv_done_flag(conv_done_flag));
    analog_core_model #(.RC_DIV(RC_DIV)) core (.pclk(pclk), .presetn(presetn),
        .level(level), .sar_trial(sar_trial), .converter_enable(converter_enable),
        .comp_in(comp_in), .rc_tick(rc_tick));
    always #50 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic t_reset();
        `CHK(converter_enable, 1'b0)
        `CHK(pin_analog, 5'h1F)
        apb(1'b0, A_CTL, 32'h0);
        `CHK(rd, 32'h0000_0000)
        apb(1'b0, A_CFG, 32'h0);
        `CHK(rd, 32'h0000_0000)
    endtask
    task automatic t_regs();
        apb(1'b1, A_CTL, 32'h0000_00FF);
        apb(1'b0, A_CTL, 32'h0);
        `CHK(rd, 32'h0000_00F9)
        `CHK(channel_select, 3'h7)
        apb(1'b1, A_CTL, 32'h0);
        apb(1'b1, A_CFG, 32'h0000_00FF);
        apb(1'b0, A_CFG, 32'h0);
        `CHK(rd, 32'h0000_008F)
        apb(1'b0, 12'h004, 32'h0);
        `CHK({err, rd}, 33'h1_0000_0000)
    endtask
    task automatic t_map();
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, A_CFG, 32'(i));
            repeat (2) @(posedge pclk);
            `CHK({pin_analog, vref_pos_pin, vref_neg_pin}, pmap[i])
        end
    endtask
    task automatic t_conv(input logic [1:0] ck, input logic j, input logic [9:0] lv,
        input int lo, input int hi);
        int t0;
        level <= lv;
        apb(1'b1, A_CFG, {24'h0, j, 7'h00});
        apb(1'b1, A_CTL, {24'h0, ck, 6'b100_001});
        apb(1'b1, A_STS, 32'h0);
        `CHK({converter_enable, channel_select}, 4'hC)
        // Wait out the 20 us acquisition before starting.
        repeat (200) @(posedge pclk);
        // The fast clock codes break the 1.6 us bit period; timing and result are both checked at them.
        apb(1'b1, A_CTL, {24'h0, ck, 6'b100_101});
        t0 = cyc;
        @(posedge pclk);
        `CHK(sar_trial, 10'h200)
        apb(1'b0, A_CTL, 32'h0);
        `CHK(rd[2], 1'b1)
        do apb(1'b0, A_STS, 32'h0); while (rd[0] !== 1'b1);
        `CHK(1'b1, (cyc - t0 >= lo) && (cyc - t0 <= hi))
        apb(1'b0, A_CTL, 32'h0);
        `CHK(rd, {24'h0, ck, 6'b100_001})
        apb(1'b0, A_HI, 32'h0);
        `CHK(rd[7:0], j ? {6'h00, lv[9:8]} : lv[9:2])
        apb(1'b0, A_LO, 32'h0);
        `CHK(rd[7:0], j ? lv[7:0] : {lv[1:0], 6'h00})
        `CHK(conv_done_flag, 1'b1)
    endtask
    task automatic t_abort();
        level <= 10'h2AA;
        apb(1'b1, A_STS, 32'h0);
        apb(1'b1, A_CTL, 32'h0000_00A5);
        repeat (10) @(posedge pclk);
        apb(1'b1, A_CTL, 32'h0000_00A1);
        repeat (3) @(posedge pclk);
        `CHK({sample_connect, conv_done_flag}, 2'b10)
        apb(1'b0, A_HI, 32'h0);
        `CHK(rd, 32'h0000_0001)
        apb(1'b0, A_LO, 32'h0);
        `CHK(rd, 32'h0000_0055)
    endtask
    task automatic t_midreset();
        apb(1'b1, A_CTL, 32'h0000_00A5);
        repeat (5) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        `CHK({converter_enable, pin_analog, sar_trial}, 16'h7C00)
        presetn <= 1'b1;
        apb(1'b0, A_CTL, 32'h0);
        `CHK(rd, 32'h0000_0000)
    endtask
    task automatic close_out();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_regs();
        t_map();
        t_conv(adc_seq_pkg::CLK_DIV2, 1'b0, 10'h2A5, 24, 34);
        t_conv(adc_seq_pkg::CLK_DIV8, 1'b1, 10'h2A5, 96, 106);
        t_conv(adc_seq_pkg::CLK_DIV32, 1'b0, 10'h3C6, 384, 394);
        t_conv(adc_seq_pkg::CLK_RC, 1'b1, 10'h155, 11 * RC_DIV, 12 * RC_DIV + 10);
        t_abort();
        t_midreset();
        close_out();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        close_out();
    end
endmodule

// file: sim/analog_core_model.sv
// Behavioural analog core: comparator against a bench-set level, plus the RC oscillator.
// Assumes sar_trial comes from the sequencer and level is set by the bench.
`timescale 1ns/1ns
module analog_core_model #(
    parameter int RC_DIV = 30
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [9:0] level,
    input wire logic [9:0] sar_trial,
    input wire logic converter_enable,
    output logic comp_in,
    output logic rc_tick
);
    logic toggle_q;
    int rc_cnt_q;
    // A powered-down comparator has no valid answer, so it toggles to expose stale sampling.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            toggle_q <= 1'b0;
        end else begin
            toggle_q <= ~toggle_q;
        end
    end
    assign comp_in = converter_enable ? (level >= sar_trial) : toggle_q;
    // The oscillator runs free with a 3 us period, inside the 2 to 6 us band.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rc_cnt_q <= 0;
        end else begin
            rc_cnt_q <= (rc_cnt_q == RC_DIV - 1) ? 0 : rc_cnt_q + 1;
        end
    end
    assign rc_tick = (rc_cnt_q == RC_DIV - 1);
endmodule
